// ==== verilog/lcd_sleep_pkg.sv ====
package lcd_sleep_pkg;

	// Register byte offsets on the APB window.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_PIXEL = 8'h0C;
	localparam logic [7:0] OFS_STATE = 8'h10;

	// Clock source codes; bit 1 set selects the internal low-rate oscillator.
	localparam logic [1:0] SRC_SYS_DIV4 = 2'h0;
	localparam logic [1:0] SRC_XTAL = 2'h1;
	localparam int SRC_LFOSC_BIT = 1;

	// Multiplex code of the single-common static mode.
	localparam logic [1:0] MUX_STATIC = 2'h0;

	// System clock divider for the divided-by-four source.
	localparam logic [1:0] DIV4_LAST = 2'h3;

	// Field layouts.
	localparam int CTRL_W = 8;
	localparam int EVT_W = 2;
	localparam int EVT_DISABLE_DONE = 0;
	localparam int EVT_FRAME = 1;
	localparam int STATE_W = 3;

	// Reset values.
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
	localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
	localparam logic [31:0] PIXEL_RST = 32'h0000_0000;

	// Control register layout, bit 0 at the bottom.
	typedef struct packed {
		logic display_interrupt_enable;
		logic waveform_b;
		logic [1:0] mux;
		logic [1:0] clk_src;
		logic sleep_shutdown_select;
		logic display_driver_enable;
	} ctrl_s;

	// Read-only state register layout.
	typedef struct packed {
		logic grounded;
		logic halted;
		logic display_active_flag;
	} state_s;

endpackage

// ==== verilog/frame_sequencer.sv ====
`timescale 1ns/1ns
module frame_sequencer import lcd_sleep_pkg::*; #(
	parameter int TICKS_PER_PHASE = 4
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic arst_n,
	// Source pins, asynchronous to clk_sys.
	input wire logic secondary_crystal_clock,
	input wire logic low_freq_internal_osc,
	// Control.
	input wire logic [1:0] clk_src,
	input wire logic [1:0] mux,
	input wire logic advance,
	input wire logic restart,
	// Sequence position.
	output logic [1:0] phase,
	output logic parity,
	output logic frame_end
);

	// Refused at elaboration: the phase counter is sixteen bits wide.
	if (TICKS_PER_PHASE < 1 || TICKS_PER_PHASE > 65535) begin
		$error("TICKS_PER_PHASE out of range");
	end

	logic [2:0] xt_q, xt_d, lf_q, lf_d;
	logic [1:0] div_q, div_d, phase_q, phase_d;
	logic [15:0] cnt_q, cnt_d;
	logic par_q, par_d, tick, last_tick;

	// Pin clocks pass two flops; the third flop only feeds the edge detect.
	always_comb begin
		xt_d = {xt_q[1:0], secondary_crystal_clock};
		lf_d = {lf_q[1:0], low_freq_internal_osc};
		div_d = div_q + 2'h1;
		if (clk_src[SRC_LFOSC_BIT]) begin
			tick = lf_q[1] & ~lf_q[2];
		end else if (clk_src == SRC_XTAL) begin
			tick = xt_q[1] & ~xt_q[2];
		end else begin
			tick = (div_q == DIV4_LAST);
		end
	end

	// The phase counter only moves while advance is high or restart clears it, so a halt simply
	// freezes phase and parity and the pins keep their last pattern.
	always_comb begin
		cnt_d = cnt_q;
		phase_d = phase_q;
		par_d = par_q;
		last_tick = (cnt_q == 16'(TICKS_PER_PHASE - 1));
		frame_end = 1'b0;
		if (restart) begin
			cnt_d = 16'h0000;
			phase_d = 2'h0;
			par_d = 1'b0;
		end else if (advance && tick) begin
			cnt_d = last_tick ? 16'h0000 : cnt_q + 16'h0001;
			if (last_tick) begin
				if (phase_q >= mux) begin
					phase_d = 2'h0;
					par_d = ~par_q;
					frame_end = 1'b1;
				end else begin
					phase_d = phase_q + 2'h1;
				end
			end
		end
	end

	// State registers.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			xt_q <= 3'h0;
			lf_q <= 3'h0;
			div_q <= 2'h0;
			cnt_q <= 16'h0000;
			phase_q <= 2'h0;
			par_q <= 1'b0;
		end else begin
			xt_q <= xt_d;
			lf_q <= lf_d;
			div_q <= div_d;
			cnt_q <= cnt_d;
			phase_q <= phase_d;
			par_q <= par_d;
		end
	end

	assign phase = phase_q;
	assign parity = par_q;

endmodule

// ==== verilog/lcd_sleep_ctrl.sv ====
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ns
// What this block does
// - Sleep with shutdown select set: stop at once, ground all pins, low power.
// - Clearing enable lets the current frame finish before the module stops.
// - At disable completion clear active flag and raise the enabled interrupt.
// - Sleep, select clear, divided system clock: halt and hold last pattern.
// - Sleep, select clear, crystal or internal oscillator: keep refreshing display.
// - Divided system clock source never runs in Sleep, whatever the select.
// - Pixel data stays unchanged during Sleep; writes then are ignored.
// - Interrupt enable with frame interrupts wakes the device at frame boundary.
// - Frame interrupts only for waveform B and a non-static multiplex.
// - After disable completes, release shared pins to ordinary port control.
module lcd_sleep_ctrl import lcd_sleep_pkg::*; #(
	parameter int SEGS = 8,
	parameter int TICKS_PER_PHASE = 4
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic arst_n,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core power state, same clock domain.
	input wire logic cpu_sleep,
	// Display clock source pins.
	input wire logic secondary_crystal_clock,
	input wire logic low_freq_internal_osc,
	// Glass drive.
	output logic [3:0] com_out,
	output logic [SEGS-1:0] seg_out,
	output logic pins_owned,
	output logic low_power,
	// System signals.
	output logic wake_req,
	output logic irq
);

	// Refused at elaboration: four commons of SEGS bits fill one data word.
	if (SEGS < 1 || SEGS > 8) begin
		$error("SEGS must be 1 to 8");
	end

	typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_STOPPING} run_e;

	localparam int PIX_W = 4 * SEGS;

	run_e st_q, st_d;
	ctrl_s ctrl_q, ctrl_d;
	logic [EVT_W-1:0] status_q, status_d, mask_q, mask_d, evt;
	logic [PIX_W-1:0] pixel_q, pixel_d;
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d;
	logic [3:0] com_q, com_d;
	logic [SEGS-1:0] seg_q, seg_d;
	logic own_q, own_d, lowp_q, lowp_d, wake_q, wake_d;
	logic setup, wr, rd, hit, status_rd;
	logic active, shutdown, halted, advance, restart;
	logic frame_irq_ok, frame_end, done;
	logic [1:0] phase;
	logic parity;
	state_s state_view;

	// The sequencer counts phases from whichever source is selected.
	frame_sequencer #(
		.TICKS_PER_PHASE(TICKS_PER_PHASE)
	) u_seq (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.secondary_crystal_clock(secondary_crystal_clock),
		.low_freq_internal_osc(low_freq_internal_osc),
		.clk_src(ctrl_q.clk_src),
		.mux(ctrl_q.mux),
		.advance(advance),
		.restart(restart),
		.phase(phase),
		.parity(parity),
		.frame_end(frame_end)
	);

	// Sleep decision. Shutdown select wins over every clock source.
	always_comb begin
		active = (st_q != ST_OFF);
		shutdown = active && cpu_sleep && ctrl_q.sleep_shutdown_select;
		halted = active && cpu_sleep && !ctrl_q.sleep_shutdown_select
			&& (ctrl_q.clk_src == SRC_SYS_DIV4);
		advance = active && !shutdown && !halted;
		restart = (st_q == ST_OFF);
	end

	// Frame events exist only for waveform B with more than one common.
	always_comb begin
		frame_irq_ok = ctrl_q.waveform_b && (ctrl_q.mux != MUX_STATIC);
		done = (st_q == ST_STOPPING) && frame_end;
		evt = '0;
		evt[EVT_DISABLE_DONE] = done;
		evt[EVT_FRAME] = frame_end && frame_irq_ok;
	end

	// Run state: an enable clear is only honoured at the next frame end,
	// so the glass never sees a half frame and no DC level is left on it.
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_OFF: begin
				if (ctrl_q.display_driver_enable) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!ctrl_q.display_driver_enable) begin
					st_d = ST_STOPPING;
				end
			end
			ST_STOPPING: begin
				if (frame_end) begin
					st_d = ST_OFF;
				end
			end
		endcase
	end

	// APB decode. The slave answers with no wait state.
	always_comb begin
		setup = psel && !penable;
		wr = psel && penable && pwrite;
		rd = setup && !pwrite;
		unique case (paddr)
			OFS_CTRL, OFS_STATUS, OFS_MASK, OFS_PIXEL, OFS_STATE: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		status_rd = psel && penable && !pwrite && (paddr == OFS_STATUS);
		state_view.grounded = shutdown;
		state_view.halted = halted;
		state_view.display_active_flag = active;
	end

	// Register writes and read capture. Read data is latched in the setup
	// cycle so prdata is a flop and stands through the access phase.
	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		pixel_d = pixel_q;
		rdata_d = rdata_q;
		err_d = err_q;
		if (setup) begin
			err_d = !hit;
			rdata_d = 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					OFS_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
					OFS_STATUS: rdata_d[EVT_W-1:0] = status_q | evt;
					OFS_MASK: rdata_d[EVT_W-1:0] = mask_q;
					OFS_PIXEL: rdata_d[PIX_W-1:0] = pixel_q;
					OFS_STATE: rdata_d[STATE_W-1:0] = state_view;
					default: rdata_d = 32'h0000_0000;
				endcase
			end
		end
		if (wr) begin
			unique case (paddr)
				OFS_CTRL: ctrl_d = pwdata[CTRL_W-1:0];
				OFS_MASK: mask_d = pwdata[EVT_W-1:0];
				OFS_PIXEL: begin
					if (!cpu_sleep) begin
						pixel_d = pwdata[PIX_W-1:0];
					end
				end
				default: pixel_d = pixel_q;
			endcase
		end
	end

	// Sticky status. A read clears the bits it returned; an event in the
	// same cycle as the clearing read survives because set wins.
	always_comb begin
		status_d = status_q;
		if (status_rd) begin
			status_d = status_q & ~rdata_q[EVT_W-1:0];
		end
		status_d = status_d | evt;
	end

	// Glass drive pattern. Each common up to mux is active in its own phase and the
	// pattern on those commons and the segments inverts every frame so the average across a pixel is
	// zero; only the plain inversion scheme is modelled here.
	always_comb begin
		com_d = com_q;
		seg_d = seg_q;
		own_d = active;
		lowp_d = shutdown;
		if (!active || shutdown) begin
			com_d = 4'h0;
			seg_d = '0;
		end else if (advance) begin
			for (int c = 0; c < 4; c++) begin
				com_d[c] = ((2'(c) == phase) ^ parity) && (2'(c) <= ctrl_q.mux);
			end
			for (int s = 0; s < SEGS; s++) begin
				seg_d[s] = pixel_q[int'(phase) * SEGS + s] ^ parity;
			end
		end
		// Otherwise halted: com and seg keep the last pattern.
	end

	// Wake the core at a frame boundary while it sleeps and the display runs.
	always_comb begin
		wake_d = cpu_sleep && frame_end && frame_irq_ok
			&& ctrl_q.display_interrupt_enable;
	end

	// Control and drive registers.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ST_OFF;
			ctrl_q <= CTRL_RST;
			status_q <= EVT_RST;
			mask_q <= EVT_RST;
			pixel_q <= PIX_W'(PIXEL_RST);
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
			com_q <= 4'h0;
			seg_q <= '0;
			own_q <= 1'b0;
			lowp_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ctrl_q <= ctrl_d;
			status_q <= status_d;
			mask_q <= mask_d;
			pixel_q <= pixel_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
			com_q <= com_d;
			seg_q <= seg_d;
			own_q <= own_d;
			lowp_q <= lowp_d;
			wake_q <= wake_d;
		end
	end

	// Outputs. The interrupt needs both the enable bit and the mask.
	assign prdata = rdata_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && err_q;
	assign com_out = com_q;
	assign seg_out = seg_q;
	assign pins_owned = own_q;
	assign low_power = lowp_q;
	assign wake_req = wake_q;
	assign irq = ctrl_q.display_interrupt_enable && |(status_q & mask_q);

endmodule

// ==== test/lcd_sleep_props.sv ====
`timescale 1ns/1ns
module lcd_sleep_props #(
	parameter int SEGS = 8
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic arst_n,
	// Bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sleep and glass.
	input wire logic cpu_sleep,
	input wire logic [3:0] com_out,
	input wire logic [SEGS-1:0] seg_out,
	input wire logic pins_owned,
	input wire logic low_power,
	input wire logic wake_req
);
	// Every check runs on the system clock and rests in reset.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_no_wait: assert property (pready)
		else $error("Bus slave inserted a wait.");
	a_err_unmapped: assert property (psel && penable && paddr > 8'h10
		|-> pslverr) else $error("Unmapped access not refused.");
	a_err_idle: assert property (!(psel && penable) |-> !pslverr)
		else $error("Error flag outside access.");
	a_read_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("Read data moved without setup.");
	a_sleep_ground: assert property (low_power
		|-> com_out == 4'h0 && seg_out == '0)
		else $error("Shutdown left glass driven.");
	a_sleep_cause: assert property (low_power |-> $past(cpu_sleep))
		else $error("Shutdown without sleep.");
	a_sleep_exit: assert property (!cpu_sleep |=> !low_power)
		else $error("Shutdown held after wake.");
	a_wake_pulse: assert property (wake_req |=> !wake_req)
		else $error("Wake request longer than a cycle.");
	a_wake_asleep: assert property (wake_req |-> $past(cpu_sleep))
		else $error("Wake request while awake.");
	a_pins_release: assert property ($fell(pins_owned)
		|-> com_out == 4'h0 && seg_out == '0)
		else $error("Pins released still driven.");
endmodule

bind lcd_sleep_ctrl lcd_sleep_props #(.SEGS(SEGS)) lcd_sleep_props_inst (
	.clk_sys(clk_sys),
	.arst_n(arst_n),
	.psel(psel),
	.penable(penable),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.cpu_sleep(cpu_sleep),
	.com_out(com_out),
	.seg_out(seg_out),
	.pins_owned(pins_owned),
	.low_power(low_power),
	.wake_req(wake_req)
);

// ==== test/lcd_glass_model.sv ====
`timescale 1ns/1ns
module lcd_glass_model #(
	parameter int SEGS = 8
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic arst_n,
	// Drive seen on the glass.
	input wire logic [3:0] com_out,
	input wire logic [SEGS-1:0] seg_out,
	// Count of pattern changes.
	output int changes
);
	logic [SEGS+3:0] last_q;

	// A held pattern means DC stress, so refresh shows as changes.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			last_q <= '0;
			changes <= 0;
		end else if ({com_out, seg_out} != last_q) begin
			last_q <= {com_out, seg_out};
			changes <= changes + 1;
		end
	end
endmodule

// ==== test/lcd_sleep_shutdown_control_tb_top.sv ====
`timescale 1ns/1ns
module lcd_sleep_shutdown_control_tb_top import lcd_sleep_pkg::*;;
	logic clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic cpu_sleep = 0, secondary_crystal_clock = 0;
	logic low_freq_internal_osc = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, px, seed = 32'h1B;
	logic pready, pslverr, pins_owned, low_power, wake_req, irq;
	logic [3:0] com_out;
	logic [7:0] seg_out;
	logic [32:0] exp_q[$];
	int failures = 0, num_checks = 0, changes, n, i;
	ctrl_s c;

	// System clock and two unrelated source clocks.
	always #5 clk_sys = ~clk_sys;
	always #15 secondary_crystal_clock = ~secondary_crystal_clock;
	always #35 low_freq_internal_osc = ~low_freq_internal_osc;

	lcd_sleep_ctrl #(.SEGS(8), .TICKS_PER_PHASE(2)) lcd_sleep_ctrl_inst (
		.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_sleep(cpu_sleep),
		.secondary_crystal_clock(secondary_crystal_clock),
		.low_freq_internal_osc(low_freq_internal_osc),
		.com_out(com_out), .seg_out(seg_out), .pins_owned(pins_owned),
		.low_power(low_power), .wake_req(wake_req), .irq(irq));

	lcd_glass_model #(.SEGS(8)) lcd_glass_model_inst (.clk_sys(clk_sys),
		.arst_n(arst_n), .com_out(com_out), .seg_out(seg_out),
		.changes(changes));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task chk(input logic [32:0] got, input logic [32:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask

	// An idle edge after each transfer keeps drives one per time step.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic err);
		exp_q.push_back({err, e});
		apb(1'b0, a, 32'h0);
	endtask

	task finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Reads meet the oldest noted expectation in the access phase.
	always @(posedge clk_sys) begin
		if (psel && penable && !pwrite && exp_q.size() > 0)
			chk({pslverr, prdata}, exp_q.pop_front());
	end

	// A hang is cut short well past the expected run.
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		finish_test();
	end

	// Main sequence.
	initial begin
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		rd(OFS_STATE, 32'h0, 1'h0);
		rd(OFS_CTRL, 32'(CTRL_RST), 1'h0);
		rd(OFS_STATUS, 32'(EVT_RST), 1'h0);
		rd(8'h20, 32'h0, 1'h1);
		px = xs();
		apb(1'b1, OFS_PIXEL, px);
		apb(1'b1, OFS_MASK, 32'h3);
		c = '0;
		c.display_driver_enable = 1'b1;
		c.mux = 2'h1;
		c.waveform_b = 1'b1;
		c.display_interrupt_enable = 1'b1;
		for (int k = 1; k < 3; k++) begin
			c.clk_src = 2'(k);
			apb(1'b1, OFS_CTRL, 32'(c));
			rd(OFS_STATE, 32'h1, 1'h0);
			cpu_sleep <= 1'b1;
			@(posedge clk_sys);
			n = changes;
			apb(1'b1, OFS_PIXEL, ~px);
			for (i = 0; i < 300 && !wake_req; i++) @(posedge clk_sys);
			chk(33'(wake_req), 33'h1);
			chk(33'(changes > n), 33'h1);
			cpu_sleep <= 1'b0;
			rd(OFS_PIXEL, px, 1'h0);
			rd(OFS_STATUS, 32'h2, 1'h0);
		end
		c.mux = MUX_STATIC;
		apb(1'b1, OFS_CTRL, 32'(c));
		apb(1'b0, OFS_STATUS, 32'h0);
		repeat (40) @(posedge clk_sys);
		rd(OFS_STATUS, 32'h0, 1'h0);
		c.clk_src = SRC_SYS_DIV4;
		c.waveform_b = 1'b0;
		c.mux = 2'h3;
		apb(1'b1, OFS_CTRL, 32'(c));
		cpu_sleep <= 1'b1;
		repeat (2) @(posedge clk_sys);
		n = changes;
		rd(OFS_STATE, 32'h3, 1'h0);
		repeat (30) @(posedge clk_sys);
		chk(33'(changes), 33'(n));
		cpu_sleep <= 1'b0;
		c.clk_src = SRC_XTAL;
		apb(1'b1, OFS_CTRL, 32'(c));
		for (i = 0; i < 300 && com_out !== 4'h1; i++) @(posedge clk_sys);
		chk(33'(seg_out), 33'(px[7:0]));
		c.display_driver_enable = 1'b0;
		apb(1'b1, OFS_CTRL, 32'(c));
		rd(OFS_STATE, 32'h1, 1'h0);
		chk(33'(pins_owned), 33'h1);
		for (i = 0; i < 300 && !irq; i++) @(posedge clk_sys);
		chk(33'(irq), 33'h1);
		@(posedge clk_sys);
		chk(33'(pins_owned), 33'h0);
		// Released pins stand low, as software would drive them as ports.
		chk(33'({com_out, seg_out}), 33'h0);
		rd(OFS_STATE, 32'h0, 1'h0);
		rd(OFS_STATUS, 32'h1, 1'h0);
		chk(33'(irq), 33'h0);
		// Sleep only after the disable finished: the glass stays quiet.
		cpu_sleep <= 1'b1;
		n = changes;
		repeat (20) @(posedge clk_sys);
		chk(33'({low_power, com_out, seg_out}), 33'h0);
		chk(33'(changes), 33'(n));
		cpu_sleep <= 1'b0;
		c.display_driver_enable = 1'b1;
		c.sleep_shutdown_select = 1'b1;
		apb(1'b1, OFS_CTRL, 32'(c));
		repeat (10) @(posedge clk_sys);
		cpu_sleep <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk(33'(low_power), 33'h1);
		chk(33'({com_out, seg_out}), 33'h0);
		cpu_sleep <= 1'b0;
		repeat (3) @(posedge clk_sys);
		finish_test();
	end
endmodule
